/* File: ocp_unit.sv */
// Purpose: output compare and pwm unit with its own 16-bit counter
// Assumes: sync sources, timer ticks and carry come from clock_i logic
// Notes:   fault inputs only store their enables here
`timescale 1ns/1ps
`default_nettype none
module ocp_unit #(
  parameter bit EVEN_UNIT = 1'b0
) (
  input  wire logic                          clock_i,
  input  wire logic                          nrst_i,
  input  wire logic [ocp_pkg::AW-1:0]        addr_i,
  input  wire logic [ocp_pkg::DW-1:0]        wdata_i,
  input  wire logic                          wr_i,
  input  wire logic                          rd_i,
  output logic      [ocp_pkg::DW-1:0]        rdata_o,
  input  wire logic [ocp_pkg::NUM_TIMERS-1:0] timer_tick_i,
  input  wire logic [ocp_pkg::SRC_NUM-1:0]   sync_src_i,
  input  wire logic                          partner_cascade_i,
  input  wire logic                          carry_i,
  output logic                               carry_o,
  output logic                               cascade_o,
  output logic                               compare_output_o,
  output logic                               compare_output_oe_o,
  output logic                               compare_irq_flag_o,
  output logic                               sync_out_o
);
  import ocp_pkg::*;

  logic [1:0]    rst_sync_ff;
  logic          rst_n;
  logic [DW-1:0] ctrl1_ff;
  logic [DW-1:0] ctrl2_ff;
  logic [DW-1:0] primary_ff;
  logic [DW-1:0] secondary_ff;
  logic [DW-1:0] period_ff;
  logic [DW-1:0] pri_buf_ff;
  logic [DW-1:0] sec_buf_ff;
  logic [DW-1:0] counter_ff;
  logic          tstat_ff;
  logic          shot_done_ff;
  logic          out_ff;
  logic          irq_ff;
  logic          carry_ff;
  logic          sync_out_ff;
  logic          oe_ff;
  logic          casc_ff;
  logic [DW-1:0] rdata_ff;

  ocp_mode_t     mode;
  logic          is_pwm;
  logic [4:0]    sync_sel;
  logic          trig_mode;
  logic          sync_mode;
  logic          tick;
  logic          cascade_active;
  logic          step_src;
  logic          hold;
  logic          running;
  logic          step;
  logic [DW-1:0] pri_cmp;
  logic [DW-1:0] sec_cmp;
  logic          pri_match;
  logic          sec_match;
  logic          period_end;
  logic [SRC_NUM:0] src_vec;
  logic          src_evt;
  logic          sync_clr;
  logic          irq_evt;
  logic          wr_ctrl1;
  logic          wr_ctrl2;
  logic [DW-1:0] nxt_rdata;

  // reset release is synchronised, assertion stays asynchronous
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      rst_sync_ff <= 2'b00;
    else
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end
  assign rst_n = rst_sync_ff[1];

  assign wr_ctrl1 = wr_i && (addr_i == ADDR_CTRL1);
  assign wr_ctrl2 = wr_i && (addr_i == ADDR_CTRL2);

  assign mode      = ocp_mode_t'(ctrl1_ff[MODE_LSB +: 3]);
  assign is_pwm    = (mode == MODE_EDGE_PWM) || (mode == MODE_CENTER_PWM);
  assign sync_sel  = ctrl2_ff[SYNC_LSB +: 5];
  assign trig_mode = (sync_sel != SYNC_OFF) && ctrl2_ff[TRIG_BIT];
  assign sync_mode = (sync_sel != SYNC_OFF) && !ctrl2_ff[TRIG_BIT];

  ocp_tick_sel u_tick (
    .tbs_i        (ctrl1_ff[TBS_LSB +: 3]),
    .timer_tick_i (timer_tick_i),
    .tick_o       (tick)
  );

  // even half counts odd half wraps instead of time base ticks
  assign cascade_active = ctrl2_ff[CASC_BIT] && partner_cascade_i;
  assign step_src = (EVEN_UNIT && cascade_active) ? carry_i : tick;

  assign hold    = trig_mode && !tstat_ff;
  assign running = (mode != MODE_OFF) && !hold;
  assign step    = running && step_src;

  assign pri_cmp    = is_pwm ? pri_buf_ff : primary_ff;
  assign sec_cmp    = is_pwm ? sec_buf_ff : secondary_ff;
  assign pri_match  = step && (counter_ff == pri_cmp);
  assign sec_match  = step && (counter_ff == sec_cmp);
  assign period_end = step && (counter_ff == period_ff);

  // source 31 is this unit's own secondary match, used for pwm period
  assign src_vec  = {sec_match, sync_src_i};
  assign src_evt  = (sync_sel != SYNC_OFF) && src_vec[sync_sel - SYNC_ONE];
  assign sync_clr = sync_mode && running && src_evt;

  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
      counter_ff <= CNT_ZERO;
    else if ((mode == MODE_OFF) || hold)
      counter_ff <= CNT_ZERO;
    else if (sync_clr)
      counter_ff <= CNT_ZERO;
    else if (step)
      counter_ff <= counter_ff + 16'h0001;
  end

  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
      carry_ff <= 1'b0;
    else
      carry_ff <= !EVEN_UNIT && step && !sync_clr
                  && (counter_ff == CNT_MAX);
  end

  // hardware set beats a software clear in the same cycle
  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
      tstat_ff <= 1'b0;
    else if (trig_mode && src_evt)
      tstat_ff <= 1'b1;
    else if (wr_ctrl2)
      tstat_ff <= wdata_i[TSTAT_BIT];
    else if (ctrl1_ff[TCM_BIT] && sec_match)
      tstat_ff <= 1'b0;
  end

  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl1_ff     <= CTRL1_RST;
      ctrl2_ff     <= CTRL2_RST;
      primary_ff   <= CNT_ZERO;
      secondary_ff <= CNT_ZERO;
      period_ff    <= CNT_ZERO;
    end
    else if (wr_i)
    begin
      case (addr_i)
        ADDR_CTRL1:     ctrl1_ff     <= wdata_i & CTRL1_WMASK;
        ADDR_CTRL2:     ctrl2_ff     <= wdata_i & CTRL2_WMASK;
        ADDR_PRIMARY:   primary_ff   <= wdata_i;
        ADDR_SECONDARY: secondary_ff <= wdata_i;
        ADDR_PERIOD:    period_ff    <= wdata_i;
        default:        ctrl1_ff     <= ctrl1_ff;
      endcase
    end
  end

  // pwm duty only changes at a period boundary, avoiding glitches
  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pri_buf_ff <= CNT_ZERO;
      sec_buf_ff <= CNT_ZERO;
    end
    else if (!is_pwm || period_end)
    begin
      pri_buf_ff <= primary_ff;
      sec_buf_ff <= secondary_ff;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
      shot_done_ff <= 1'b0;
    else if (wr_ctrl1)
      shot_done_ff <= 1'b0;
    else if ((mode == MODE_SINGLE) && pri_match)
      shot_done_ff <= 1'b1;
    else if ((mode == MODE_DOUBLE) && sec_match && out_ff)
      shot_done_ff <= 1'b1;
  end

  // default level is low; a control rewrite returns it there
  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
      out_ff <= 1'b0;
    else if (wr_ctrl1)
      out_ff <= 1'b0;
    else
    begin
      case (mode)
        MODE_OFF:
          out_ff <= 1'b0;
        MODE_SINGLE:
          if (pri_match && !shot_done_ff)
            out_ff <= 1'b1;
        MODE_DOUBLE:
          if (sec_match && out_ff)
            out_ff <= 1'b0;
          else if (pri_match && !shot_done_ff)
            out_ff <= 1'b1;
        MODE_TOGGLE:
          if (pri_match)
            out_ff <= !out_ff;
        MODE_EDGE_PWM:
          if (sec_buf_ff > period_ff)
            out_ff <= 1'b1;
          else if (period_end)
            out_ff <= (primary_ff != CNT_ZERO);
          else if (pri_match)
            out_ff <= 1'b0;
        MODE_CENTER_PWM:
          if (sec_buf_ff > period_ff)
            out_ff <= 1'b1;
          else if (sec_match)
            out_ff <= 1'b0;
          else if (pri_match)
            out_ff <= 1'b1;
        default:
          out_ff <= 1'b0;
      endcase
    end
  end

  always_comb
  begin
    case (mode)
      MODE_SINGLE: irq_evt = pri_match && !shot_done_ff;
      MODE_TOGGLE: irq_evt = pri_match;
      MODE_DOUBLE: irq_evt = sec_match && out_ff;
      MODE_EDGE_PWM, MODE_CENTER_PWM: irq_evt = sec_match;
      default:     irq_evt = 1'b0;
    endcase
  end

  // set wins over the write-one clear
  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
      irq_ff <= 1'b0;
    else if (irq_evt)
      irq_ff <= 1'b1;
    else if (wr_i && (addr_i == ADDR_STATUS) && wdata_i[IRQ_BIT])
      irq_ff <= 1'b0;
  end

  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_out_ff <= 1'b0;
      oe_ff       <= 1'b0;
      casc_ff     <= 1'b0;
    end
    else
    begin
      sync_out_ff <= sec_match;
      oe_ff       <= !ctrl2_ff[TRIS_BIT];
      casc_ff     <= ctrl2_ff[CASC_BIT];
    end
  end

  always_comb
  begin
    nxt_rdata = CNT_ZERO;
    case (addr_i)
      ADDR_CTRL1:     nxt_rdata = ctrl1_ff;
      ADDR_CTRL2:
      begin
        nxt_rdata = ctrl2_ff;
        nxt_rdata[TSTAT_BIT] = tstat_ff;
      end
      ADDR_PRIMARY:   nxt_rdata = primary_ff;
      ADDR_SECONDARY: nxt_rdata = secondary_ff;
      ADDR_PERIOD:    nxt_rdata = period_ff;
      ADDR_COUNTER:   nxt_rdata = counter_ff;
      ADDR_STATUS:
      begin
        nxt_rdata[IRQ_BIT] = irq_ff;
        nxt_rdata[OUT_BIT] = out_ff;
      end
      default:        nxt_rdata = CNT_ZERO;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
      rdata_ff <= CNT_ZERO;
    else
      rdata_ff <= rd_i ? nxt_rdata : CNT_ZERO;
  end

  assign rdata_o             = rdata_ff;
  assign carry_o             = carry_ff;
  assign cascade_o           = casc_ff;
  assign compare_output_o    = out_ff;
  assign compare_output_oe_o = oe_ff;
  assign compare_irq_flag_o  = irq_ff;
  assign sync_out_o          = sync_out_ff;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n);

  a_wrap_zero: assert property (
    (step && !sync_clr && counter_ff == CNT_MAX) |=> counter_ff == CNT_ZERO)
    else $error("counter did not wrap to zero");
  a_count_up: assert property (
    (step && !sync_clr && mode == $past(mode))
    |=> counter_ff == $past(counter_ff) + 16'h0001 || wr_ctrl1 || $past(wr_ctrl1))
    else $error("counter did not step by one");
  a_sync_clear: assert property (
    sync_clr |=> counter_ff == CNT_ZERO)
    else $error("sync event did not clear counter");
  a_trig_hold: assert property (
    hold [*2] |-> counter_ff == CNT_ZERO)
    else $error("counter moved while waiting for trigger");
  a_trig_start: assert property (
    (trig_mode && src_evt) |=> tstat_ff)
    else $error("trigger event did not set status");
  a_carry_roll: assert property (
    carry_ff |-> $past(counter_ff) == CNT_MAX && counter_ff == CNT_ZERO)
    else $error("carry without rollover");
  a_toggle_out: assert property (
    (mode == MODE_TOGGLE && pri_match && !wr_ctrl1) |=> out_ff != $past(out_ff))
    else $error("toggle mode did not toggle");
  a_double_ret: assert property (
    (mode == MODE_DOUBLE && out_ff && sec_match && !wr_ctrl1) |=> !out_ff)
    else $error("double compare did not return to default");
  a_single_once: assert property (
    (mode == MODE_SINGLE && shot_done_ff && !wr_ctrl1) |=> !irq_evt || wr_ctrl1)
    else $error("single shot fired twice");
  a_irq_set: assert property (
    irq_evt |=> compare_irq_flag_o)
    else $error("interrupt flag missed an event");
  a_full_duty: assert property (
    (is_pwm && sec_buf_ff > period_ff && !wr_ctrl1) |=> compare_output_o)
    else $error("full duty output not high");
  a_buffer_hold: assert property (
    (is_pwm && !period_end && !wr_ctrl1) |=> pri_buf_ff == $past(pri_buf_ff))
    else $error("pwm buffer changed mid period");

  c_toggle: cover property (mode == MODE_TOGGLE && pri_match);
  c_pwm_full: cover property (is_pwm && sec_buf_ff > period_ff && out_ff);
  c_trig_go: cover property (hold ##1 !hold && running);
  c_carry: cover property (carry_ff);
endmodule : ocp_unit
`default_nettype wire

/* File: ocp_pkg.sv */
// Purpose: shared constants for the output compare / pwm unit
// Assumes: 16-bit registers on a plain strobe port
// Notes:   offsets are word indices on a 3-bit address
`default_nettype none
package ocp_pkg;
  localparam int DW = 16;
  localparam int AW = 3;
  localparam int NUM_TIMERS = 5;
  localparam int SRC_NUM = 30;

  localparam logic [AW-1:0] ADDR_CTRL1     = 3'h0;
  localparam logic [AW-1:0] ADDR_CTRL2     = 3'h1;
  localparam logic [AW-1:0] ADDR_PRIMARY   = 3'h2;
  localparam logic [AW-1:0] ADDR_SECONDARY = 3'h3;
  localparam logic [AW-1:0] ADDR_PERIOD    = 3'h4;
  localparam logic [AW-1:0] ADDR_COUNTER   = 3'h5;
  localparam logic [AW-1:0] ADDR_STATUS    = 3'h6;

  // compare_control_1 fields
  localparam int MODE_LSB = 0;
  localparam int TCM_BIT  = 3;
  localparam int FLT_LSB  = 7;
  localparam int TBS_LSB  = 10;
  // compare_control_2 fields
  localparam int SYNC_LSB  = 0;
  localparam int TRIS_BIT  = 5;
  localparam int TSTAT_BIT = 6;
  localparam int TRIG_BIT  = 7;
  localparam int CASC_BIT  = 8;
  // status fields
  localparam int IRQ_BIT = 0;
  localparam int OUT_BIT = 1;

  localparam logic [DW-1:0] CTRL1_RST   = 16'h0000;
  localparam logic [DW-1:0] CTRL2_RST   = 16'h0000;
  localparam logic [DW-1:0] CTRL1_WMASK = 16'h1F8F;
  localparam logic [DW-1:0] CTRL2_WMASK = 16'h01BF;
  localparam logic [DW-1:0] CNT_MAX     = 16'hFFFF;
  localparam logic [DW-1:0] CNT_ZERO    = 16'h0000;

  localparam logic [4:0] SYNC_OFF  = 5'h00;
  localparam logic [4:0] SYNC_SELF = 5'h1F;
  localparam logic [4:0] SYNC_ONE  = 5'h01;

  localparam logic [2:0] TBS_PERIPH = 3'h7;

  typedef enum logic [2:0] {
    MODE_OFF        = 3'b000,
    MODE_SINGLE     = 3'b001,
    MODE_DOUBLE     = 3'b010,
    MODE_TOGGLE     = 3'b011,
    MODE_EDGE_PWM   = 3'b110,
    MODE_CENTER_PWM = 3'b111
  } ocp_mode_t;
endpackage : ocp_pkg
`default_nettype wire

/* File: ocp_tick_sel.sv */
// Purpose: picks the count enable from the time base select field
// Assumes: timer prescaler ticks are one-cycle pulses on clock_i
// Notes:   reserved selections give no ticks, so the counter stands
`timescale 1ns/1ps
`default_nettype none
module ocp_tick_sel (
  input  wire logic [2:0]                    tbs_i,
  input  wire logic [ocp_pkg::NUM_TIMERS-1:0] timer_tick_i,
  output logic                               tick_o
);
  import ocp_pkg::*;

  logic [NUM_TIMERS-1:0] hit;

  genvar g;
  generate
    for (g = 0; g < NUM_TIMERS; g++)
    begin : g_sel
      assign hit[g] = timer_tick_i[g] && (tbs_i == 3'(g));
    end
  endgenerate

  // peripheral clock selection counts on every cycle
  assign tick_o = (tbs_i == TBS_PERIPH) || (|hit);
endmodule : ocp_tick_sel
`default_nettype wire

/* File: ocp_load_model.sv */
// Purpose: load on the compare pin, counts high cycles and rising edges
// Assumes: pin has a pull-down, so a released pin reads low
// Notes:   both counts restart on clear_i
`timescale 1ns/1ps
`default_nettype none
module ocp_load_model (
  input  wire logic        clock_i,
  input  wire logic        clear_i,
  input  wire logic        pin_i,
  input  wire logic        oe_i,
  output logic      [31:0] high_cnt_o,
  output logic      [31:0] rise_cnt_o
);
  logic level;
  logic level_ff;

  // undriven pin falls to the pull-down level
  assign level = oe_i & pin_i;

  always_ff @(posedge clock_i)
  begin
    level_ff <= level;
    if (clear_i)
    begin
      high_cnt_o <= 32'h0;
      rise_cnt_o <= 32'h0;
    end
    else
    begin
      high_cnt_o <= high_cnt_o + {31'h0, level};
      rise_cnt_o <= rise_cnt_o + {31'h0, level & ~level_ff};
    end
  end
endmodule : ocp_load_model
`default_nettype wire

/* File: ocp_unit_tb.sv */
// Purpose: self-checking bench for the compare / pwm unit
// Assumes: odd unit is dut_u, an even unit is cascaded behind it
// Notes:   pwm duty judged over a window, period latency is the design's
`timescale 1ns/1ps
`default_nettype none
module ocp_unit_tb;
  import ocp_pkg::*;
  localparam int PER = 19;
  logic                  clock_i;
  logic                  nrst_i;
  logic [AW-1:0]         addr_i;
  logic [DW-1:0]         wdata_i;
  logic                  wr_i;
  logic                  rd_i;
  logic [DW-1:0]         rdata_o;
  logic [NUM_TIMERS-1:0] tick;
  logic [SRC_NUM-1:0]    sync_src;
  logic                  carry_o;
  logic                  out_pin;
  logic                  out_oe;
  logic                  irq;
  logic                  clear;
  logic [31:0]           high_cnt;
  logic [31:0]           rise_cnt;
  logic                  sel_even;
  logic [DW-1:0]         rdata_odd;
  logic [DW-1:0]         rdata_even;
  logic                  casc_odd;
  logic                  casc_even;
  logic                  sync_out;
  int                    sync_seen;
  logic [DW-1:0]         rd_val;
  logic [DW-1:0]         c0;
  logic [31:0]           r;
  int                    err_count;
  int                    n_tests;
  int                    seed;
  int                    k;
  int                    d;

  ocp_unit #(.EVEN_UNIT(1'b0)) dut_u (
    .clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i && !sel_even), .rd_i(rd_i && !sel_even),
    .rdata_o(rdata_odd), .timer_tick_i(tick),
    .sync_src_i(sync_src), .partner_cascade_i(casc_even), .carry_i(1'b0),
    .carry_o(carry_o), .cascade_o(casc_odd), .compare_output_o(out_pin),
    .compare_output_oe_o(out_oe), .compare_irq_flag_o(irq),
    .sync_out_o(sync_out));
  // even half shares the bus; only the selected unit sees a strobe
  ocp_unit #(.EVEN_UNIT(1'b1)) even_u (
    .clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i && sel_even), .rd_i(rd_i && sel_even),
    .rdata_o(rdata_even), .timer_tick_i(tick),
    .sync_src_i(sync_src), .partner_cascade_i(casc_odd), .carry_i(carry_o),
    .carry_o(), .cascade_o(casc_even), .compare_output_o(),
    .compare_output_oe_o(), .compare_irq_flag_o(), .sync_out_o());
  // unselected unit reads zero, so the two words can be merged
  assign rdata_o = rdata_odd | rdata_even;

  always @(posedge clock_i)
  begin
    if (clear)
      sync_seen <= 0;
    else
      sync_seen <= sync_seen + int'(sync_out);
  end
  ocp_load_model load_u (
    .clock_i(clock_i), .clear_i(clear), .pin_i(out_pin), .oe_i(out_oe),
    .high_cnt_o(high_cnt), .rise_cnt_o(rise_cnt));

  initial
  begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  task automatic final_report;
    $display("errors %0d of %0d checks", err_count, n_tests);
    if (err_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] v);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
    @(posedge clock_i);
  endtask : wr

  task automatic rd(input logic [AW-1:0] a);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 rd_val = rdata_o;
    @(posedge clock_i);
  endtask : rd

  // counter steps only while ticks run, so match points are exact
  task automatic run_ticks(input int n);
    tick <= 5'h1F;
    repeat (n) @(posedge clock_i);
    tick <= 5'h00;
    @(posedge clock_i);
    #1;
  endtask : run_ticks

  task automatic sync_pulse;
    sync_src[0] <= 1'b1;
    clear <= 1'b1;
    @(posedge clock_i);
    sync_src[0] <= 1'b0;
    clear <= 1'b0;
    @(posedge clock_i);
  endtask : sync_pulse

  function automatic int exp_high(input logic [2:0] m, input int p,
                                  input int s);
    // edge pwm rises on the period count itself, so duty plus one
    return (m == MODE_CENTER_PWM) ? s - p : p + 1;
  endfunction : exp_high

  task automatic pwm_case(input logic [2:0] m, input logic [DW-1:0] p,
                          input logic [DW-1:0] s);
    int e;
    e = exp_high(m, p, s);
    wr(ADDR_CTRL1, 16'h0000);
    wr(ADDR_PRIMARY, p);
    wr(ADDR_SECONDARY, s);
    wr(ADDR_CTRL1, 16'h1C80 | {13'h0, m});
    repeat (60) @(posedge clock_i);
    clear <= 1'b1;
    @(posedge clock_i);
    clear <= 1'b0;
    repeat (200) @(posedge clock_i);
    #1;
    if (s > PER)
      chk("pwm full duty", 200, high_cnt);
    else
      chk("pwm duty", 1, rise_cnt > 0 && high_cnt >= e * (rise_cnt - 1)
          && high_cnt <= e * (rise_cnt + 1));
  endtask : pwm_case

  initial
  begin
    repeat (100000) @(posedge clock_i);
    err_count++;
    final_report;
  end

  initial
  begin
    nrst_i = 1'b0;
    addr_i = '0;
    wdata_i = '0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    tick = '0;
    sync_src = '0;
    clear = 1'b0;
    sel_even = 1'b0;
    err_count = 0;
    n_tests = 0;
    seed = 32'h5B35;
    repeat (12) @(posedge clock_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    rd(ADDR_CTRL1);
    chk("ctrl1 reset", CTRL1_RST, rd_val);
    rd(ADDR_CTRL2);
    chk("ctrl2 reset", CTRL2_RST, rd_val);
    rd(3'h7);
    chk("unmapped read", 0, rd_val);
    #1 chk("pin enabled", 1, out_oe);
    wr(ADDR_CTRL1, 16'hFFFF);
    rd(ADDR_CTRL1);
    chk("ctrl1 fields", CTRL1_WMASK, rd_val);
    wr(ADDR_CTRL2, 16'h0120);
    #1 chk("pin released", 0, out_oe);
    chk("cascade bit", 1, casc_odd);
    wr(ADDR_CTRL2, 16'h0000);
    // time bases 0 to 6, reserved ones included, with random ticks
    for (int n = 0; n < 7; n++)
    begin
      wr(ADDR_CTRL1, {3'h0, n[2:0], 10'h003});
      rd(ADDR_COUNTER);
      c0 = rd_val;
      k = 0;
      repeat (16)
      begin
        r = $random(seed);
        tick <= r[4:0];
        if (n < 5)
          k += r[n];
        @(posedge clock_i);
      end
      tick <= 5'h00;
      rd(ADDR_COUNTER);
      chk("ticks counted", k, 16'(rd_val - c0));
    end
    wr(ADDR_CTRL2, 16'h0081);
    wr(ADDR_CTRL1, 16'h1C03);
    repeat (10) @(posedge clock_i);
    rd(ADDR_COUNTER);
    chk("held counter", 0, rd_val);
    sync_pulse;
    repeat (10) @(posedge clock_i);
    rd(ADDR_CTRL2);
    chk("trigger status", 1, rd_val[TSTAT_BIT]);
    rd(ADDR_COUNTER);
    chk("counter runs", 1, rd_val > 16'h0005);
    wr(ADDR_SECONDARY, 16'h0040);
    wr(ADDR_CTRL1, 16'h1C0B);
    repeat (70) @(posedge clock_i);
    rd(ADDR_CTRL2);
    chk("status auto clear", 0, rd_val[TSTAT_BIT]);
    wr(ADDR_CTRL2, 16'h0001);
    wr(ADDR_PRIMARY, 16'h000A);
    wr(ADDR_SECONDARY, 16'h0014);
    // double compare: fires, stays quiet, fires again after ctrl1 rewrite
    for (int i = 0; i < 3; i++)
    begin
      if (i != 1)
        wr(ADDR_CTRL1, 16'h0002);
      if (i == 0)
        wr(ADDR_STATUS, 16'h0001);
      sync_pulse;
      rd(ADDR_COUNTER);
      chk("sync clears", 0, rd_val);
      run_ticks(40);
      chk("shot count", (i == 1) ? 0 : 1, rise_cnt);
      chk("shot width", (i == 1) ? 0 : 10, high_cnt);
      chk("sync out", 1, sync_seen);
      if (i == 0)
      begin
        chk("flag on secondary", 1, irq);
        wr(ADDR_STATUS, 16'h0001);
        #1 chk("flag cleared", 0, irq);
      end
    end
    wr(ADDR_CTRL1, 16'h0003);
    for (int i = 0; i < 2; i++)
    begin
      sync_pulse;
      run_ticks(40);
      chk("toggle level", (i == 0), out_pin);
    end
    rd(ADDR_STATUS);
    chk("status", 16'h0001, rd_val);
    wr(ADDR_CTRL2, 16'h0000);
    // even unit first, cascade bit set, its mode before the odd one
    sel_even <= 1'b1;
    wr(ADDR_CTRL2, 16'h0100);
    wr(ADDR_CTRL1, 16'h0003);
    sel_even <= 1'b0;
    wr(ADDR_CTRL2, 16'h0100);
    wr(ADDR_CTRL1, 16'h1C03);
    k = 0;
    while (carry_o !== 1'b1 && k < 70000)
    begin
      @(posedge clock_i);
      #1 k++;
    end
    chk("wrap seen", 1, k < 70000);
    rd(ADDR_COUNTER);
    chk("count after wrap", 1, rd_val < 16'h0010);
    sel_even <= 1'b1;
    rd(ADDR_COUNTER);
    chk("high half count", 1, rd_val);
    sel_even <= 1'b0;
    wr(ADDR_CTRL2, {11'h000, SYNC_SELF});
    wr(ADDR_PERIOD, 16'(PER));
    r = $random(seed);
    d = 1 + r[3:0];
    pwm_case(MODE_EDGE_PWM, 16'(d), 16'(PER));
    pwm_case(MODE_CENTER_PWM, 16'h0005, 16'h000C);
    pwm_case(MODE_EDGE_PWM, 16'(d), 16'(PER + 5));
    final_report;
  end
endmodule : ocp_unit_tb
`default_nettype wire
